// ===== verilog/sysreg_move_map.vh
`ifndef SYSREG_MOVE_MAP_VH
`define SYSREG_MOVE_MAP_VH

// primary and extended opcodes
`define OP_FIXED 6'h1F
`define OP_FLOAT 6'h3F
`define XO_SEG_READ 10'h293
`define XO_COND_WRITE 10'h090
`define XO_FS_CLEAR 10'h046
`define XO_FS_SET 10'h026

// instruction fields, bit 31 of the word is the msb
`define F_PRI_HI 31
`define F_PRI_LO 26
`define F_TGT_HI 25
`define F_TGT_LO 21
`define F_IDX_HI 15
`define F_IDX_LO 11
`define F_MASK_HI 19
`define F_MASK_LO 12
`define F_XO_HI 10
`define F_XO_LO 1
`define F_REC 0

// derived status bits that cannot be written directly
`define FS_EN_SUM_IDX 5'h01
`define FS_INV_SUM_IDX 5'h02

// apb byte offsets
`define A_CTRL 8'h00
`define A_INT_STATUS 8'h04
`define A_INT_MASK 8'h08
`define A_COND 8'h0C
`define A_FSCR 8'h10
`define A_GPR_SEL 8'h14
`define A_GPR_DATA 8'h18
`define A_SEG_SEL 8'h1C
`define A_SEG_DATA 8'h20

// status and control bits
`define CTRL_SUPER 0
`define INT_PRIV 0
`define INT_DONE 1
`define INT_W 2

// reset values
`define RST_CTRL 1'h0
`define RST_WORD 32'h0000_0000
`define RST_INT 2'h0

`endif

// ===== verilog/sysreg_move_decode_exec.v
`timescale 1ns/1ps
`default_nettype none
`include "sysreg_move_map.vh"

// Function
// RULE1 - decode indirect segment read, opcode 31/659
// RULE2 - index gpr top nibble picks segment register
// RULE3 - segment read leaves xer and cond alone
// RULE4 - segment read only in supervisor state
// RULE5 - decode masked cond write, opcode 31/144
// RULE6 - copy masked nibbles of source into cond
// RULE7 - unmasked cond nibbles and xer unchanged
// RULE8 - software should set one mask bit
// RULE9 - decode status bit clear, opcode 63/70
// RULE10 - decode status bit set, opcode 63/38
// RULE11 - record copies four fp bits to cond field 1
// RULE12 - no record, cond untouched; xer never
// RULE13 - status bits 1-2 not directly writable
// RULE14 - problem state read raises program exception
module sysreg_move_decode_exec #(
  parameter NUM_GPR = 32,
  parameter NUM_SEG = 16
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire issue_valid,
  input wire [31:0] issue_instr,
  output reg exec_done,
  output reg priv_exc,
  output reg irq
);

  reg super_ff;
  reg [`INT_W-1:0] int_status_ff;
  reg [`INT_W-1:0] int_mask_ff;
  reg [31:0] cond_ff;
  reg [31:0] fscr_ff;
  reg [4:0] gpr_sel_ff;
  reg [3:0] seg_sel_ff;
  reg [31:0] nxt_cond;
  reg [31:0] nxt_fscr;
  reg [`INT_W-1:0] nxt_int_status;
  reg [`INT_W-1:0] nxt_int_mask;
  reg [31:0] rd_mux;
  reg rd_hit;
  wire [NUM_GPR*32-1:0] gpr_flat;
  wire [NUM_SEG*32-1:0] seg_flat;

  // apb phases
  wire setup = psel & ~penable;
  wire acc_wr = psel & penable & pready & pwrite;
  // write strobes, one per register
  wire w_ctrl = acc_wr & (paddr == `A_CTRL);
  wire w_int = acc_wr & (paddr == `A_INT_STATUS);
  wire w_mask = acc_wr & (paddr == `A_INT_MASK);
  wire w_cond = acc_wr & (paddr == `A_COND);
  wire w_fscr = acc_wr & (paddr == `A_FSCR);
  wire w_gsel = acc_wr & (paddr == `A_GPR_SEL);
  wire w_gdat = acc_wr & (paddr == `A_GPR_DATA);
  wire w_ssel = acc_wr & (paddr == `A_SEG_SEL);
  wire w_sdat = acc_wr & (paddr == `A_SEG_DATA);

  // instruction fields
  wire [5:0] pri = issue_instr[`F_PRI_HI:`F_PRI_LO];
  wire [9:0] xo = issue_instr[`F_XO_HI:`F_XO_LO];
  wire [4:0] target_gpr = issue_instr[`F_TGT_HI:`F_TGT_LO];
  wire [4:0] source_gpr = target_gpr;
  wire [4:0] status_bit_index = target_gpr;
  wire [4:0] index_gpr = issue_instr[`F_IDX_HI:`F_IDX_LO];
  wire [7:0] cond_field_mask = issue_instr[`F_MASK_HI:`F_MASK_LO];
  wire record_bit = issue_instr[`F_REC];

  // RULE1 segment read decode
  wire is_seg_read = issue_valid & (pri == `OP_FIXED) &
    (xo == `XO_SEG_READ);
  // RULE5 masked cond write decode
  wire is_cond_write = issue_valid & (pri == `OP_FIXED) &
    (xo == `XO_COND_WRITE);
  // RULE9 status clear decode
  wire fp_status_bit_clear = issue_valid & (pri == `OP_FLOAT) &
    (xo == `XO_FS_CLEAR);
  // RULE10 status set decode
  wire fp_status_bit_set = issue_valid & (pri == `OP_FLOAT) &
    (xo == `XO_FS_SET);

  // RULE4 supervisor only
  wire seg_ok = is_seg_read & super_ff;
  // RULE14 problem state trap
  wire seg_trap = is_seg_read & ~super_ff;

  // any instruction that completed
  wire exec_any = seg_ok | is_cond_write | fp_status_bit_clear |
    fp_status_bit_set;

  wire [31:0] index_val = gpr_flat[index_gpr*32 +: 32];
  wire [31:0] source_val = gpr_flat[source_gpr*32 +: 32];
  // RULE2 bits 0-3 of index gpr
  wire [3:0] seg_pick = index_val[31:28];
  wire [31:0] seg_val = seg_flat[seg_pick*32 +: 32];

  // RULE13 summary bits protected
  wire fs_writable = (status_bit_index != `FS_EN_SUM_IDX) &
    (status_bit_index != `FS_INV_SUM_IDX);
  // bit index counts from the msb
  wire [4:0] fs_pos = 5'd31 - status_bit_index;

  genvar g;
  generate
    // instruction result wins over a software write
    for (g = 0; g < NUM_GPR; g = g + 1) begin : gpr_e
      reg [31:0] q_ff;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          q_ff <= `RST_WORD;
        // RULE2 write segment value
        end else if (seg_ok && target_gpr == g) begin
          q_ff <= seg_val;
        end else if (w_gdat && gpr_sel_ff == g) begin
          q_ff <= pwdata;
        end
      end
      assign gpr_flat[g*32 +: 32] = q_ff;
    end
    // segment registers are loaded by software only
    for (g = 0; g < NUM_SEG; g = g + 1) begin : seg_e
      reg [31:0] q_ff;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          q_ff <= `RST_WORD;
        end else if (w_sdat && seg_sel_ff == g) begin
          q_ff <= pwdata;
        end
      end
      assign seg_flat[g*32 +: 32] = q_ff;
    end
  endgenerate

  // status register next value
  always @* begin
    // software may load bits 1-2, instructions may not
    nxt_fscr = w_fscr ? pwdata : fscr_ff;
    // RULE9 clear indexed bit
    if (fp_status_bit_clear && fs_writable) begin
      nxt_fscr[fs_pos] = 1'b0;
    end
    // RULE10 set indexed bit
    if (fp_status_bit_set && fs_writable) begin
      nxt_fscr[fs_pos] = 1'b1;
    end
  end

  // condition register next value
  integer k;
  always @* begin
    // software load first, instruction wins
    nxt_cond = w_cond ? pwdata : cond_ff;
    // RULE6 masked nibble copy
    // RULE7 clear mask keeps nibble
    for (k = 0; k < 8; k = k + 1) begin
      if (is_cond_write && cond_field_mask[7-k]) begin
        nxt_cond[31-4*k -: 4] = source_val[31-4*k -: 4];
      end
    end
    // RULE11 record copies to field 1
    // RULE12 record clear leaves cond
    if ((fp_status_bit_clear | fp_status_bit_set) && record_bit) begin
      nxt_cond[27:24] = nxt_fscr[31:28];
    end
    // RULE3 field 0 left as is on record
  end

  // interrupt status, set beats clear
  always @* begin
    nxt_int_status = int_status_ff;
    // software clears by writing ones
    if (w_int) begin
      nxt_int_status = int_status_ff & ~pwdata[`INT_W-1:0];
    end
    // RULE14 trap sets its bit
    nxt_int_status[`INT_PRIV] = nxt_int_status[`INT_PRIV] | seg_trap;
    nxt_int_status[`INT_DONE] = nxt_int_status[`INT_DONE] | exec_any;
  end

  // mask next value, so irq follows a mask write at once
  always @* begin
    nxt_int_mask = int_mask_ff;
    if (w_mask) begin
      nxt_int_mask = pwdata[`INT_W-1:0];
    end
  end

  // read mux
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `A_CTRL: begin
        rd_mux[`CTRL_SUPER] = super_ff;
      end
      `A_INT_STATUS: begin
        rd_mux[`INT_W-1:0] = int_status_ff;
      end
      `A_INT_MASK: begin
        rd_mux[`INT_W-1:0] = int_mask_ff;
      end
      `A_COND: begin
        rd_mux = cond_ff;
      end
      `A_FSCR: begin
        rd_mux = fscr_ff;
      end
      `A_GPR_SEL: begin
        rd_mux[4:0] = gpr_sel_ff;
      end
      `A_GPR_DATA: begin
        rd_mux = gpr_flat[gpr_sel_ff*32 +: 32];
      end
      `A_SEG_SEL: begin
        rd_mux[3:0] = seg_sel_ff;
      end
      `A_SEG_DATA: begin
        rd_mux = seg_flat[seg_sel_ff*32 +: 32];
      end
      // unmapped offsets answer with an error
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // software control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      super_ff <= `RST_CTRL;
      int_mask_ff <= `RST_INT;
      gpr_sel_ff <= 5'h00;
      seg_sel_ff <= 4'h0;
    end else begin
      if (w_ctrl) begin
        super_ff <= pwdata[`CTRL_SUPER];
      end
      int_mask_ff <= nxt_int_mask;
      if (w_gsel) begin
        gpr_sel_ff <= pwdata[4:0];
      end
      if (w_ssel) begin
        seg_sel_ff <= pwdata[3:0];
      end
    end
  end

  // architected state and interrupt
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_ff <= `RST_WORD;
      fscr_ff <= `RST_WORD;
      int_status_ff <= `RST_INT;
      irq <= 1'b0;
    end else begin
      cond_ff <= nxt_cond;
      fscr_ff <= nxt_fscr;
      int_status_ff <= nxt_int_status;
      // level follows status and mask as they are written
      irq <= |(nxt_int_status & nxt_int_mask);
    end
  end

  // apb answer in first access cycle, no wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= `RST_WORD;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? `RST_WORD : rd_mux;
        pslverr <= ~rd_hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // one-cycle outcome pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_done <= 1'b0;
      priv_exc <= 1'b0;
    end else begin
      exec_done <= exec_any;
      // RULE14 trapped read pulses
      priv_exc <= seg_trap;
    end
  end

endmodule // sysreg_move_decode_exec

`default_nettype wire

// ===== testbench/sysreg_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "sysreg_move_map.vh"
module sysreg_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire issue_valid,
  input wire [31:0] issue_instr,
  input wire exec_done,
  input wire priv_exc
);
  wire [9:0] xo = issue_instr[10:1];
  wire [4:0] bit_idx = issue_instr[25:21];
  wire fix_op = issue_valid && issue_instr[31:26] == `OP_FIXED;
  wire fo = issue_valid && issue_instr[31:26] == `OP_FLOAT;
  wire fl = fo && bit_idx != 5'h01 && bit_idx != 5'h02;
  wire seg = fix_op && xo == `XO_SEG_READ;
  wire crw = fix_op && xo == `XO_COND_WRITE;
  wire fop = fo && (xo == `XO_FS_CLEAR || xo == `XO_FS_SET);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SEG: assert property (seg |=> exec_done ^ priv_exc)
    else $error("segment read outcome wrong");
  AST_NOPRIV: assert property (!seg |=> !priv_exc)
    else $error("trap without segment read");
  AST_CRW: assert property (crw |=> exec_done)
    else $error("cr write not done");
  AST_FCLR: assert property (fl && xo == `XO_FS_CLEAR |=> exec_done)
    else $error("bit clear not done");
  AST_FSET: assert property (fl && xo == `XO_FS_SET |=> exec_done)
    else $error("bit set not done");
  AST_UNREC: assert property (!(seg || crw || fop) |=> !exec_done)
    else $error("done without instruction");
  AST_RDY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_ERR: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
endmodule // sysreg_chk
bind sysreg_move_decode_exec sysreg_chk i_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .issue_valid(issue_valid),
  .issue_instr(issue_instr), .exec_done(exec_done), .priv_exc(priv_exc));
`default_nettype wire

// ===== testbench/issue_model.sv
`timescale 1ns/1ps
`default_nettype none
module issue_model (
  input wire pclk,
  output logic issue_valid,
  output logic [31:0] issue_instr
);
  logic [31:0] q[$];
  initial begin
    issue_valid = 1'b0;
    issue_instr = 32'h0;
  end
  // one word a cycle; idle word keeps changing
  always @(posedge pclk) begin
    issue_valid <= q.size() != 0;
    issue_instr <= q.size() != 0 ? q.pop_front() : ~issue_instr;
  end
endmodule // issue_model
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sysreg_move_map.vh"
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, v, c, s, mx, fs, w;
  logic [7:0] m;
  logic [4:0] b;
  wire pready, pslverr, exec_done, priv_exc, irq, issue_valid;
  wire [31:0] prdata, issue_instr;
  logic [32:0] q[$];
  int err_total = 0, checked = 0;
  sysreg_move_decode_exec i_sysreg_move_decode_exec (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .exec_done(exec_done),
    .priv_exc(priv_exc), .irq(irq));
  issue_model i_issue_model (.pclk(pclk), .issue_valid(issue_valid),
    .issue_instr(issue_instr));
  initial forever #50 pclk = ~pclk;
  task cmp(input logic [32:0] g, input logic [32:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task apb(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    if (!we) q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task run(input logic [31:0] x);
    i_issue_model.q.push_back(x);
    while (i_issue_model.q.size() != 0) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp({pslverr, prdata}, q.pop_front());
  initial begin
    #1000000;
    err_total++;
    end_sim;
  end
  initial begin
    void'($urandom(73));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`A_FSCR, `RST_WORD);
    rd(`A_COND, `RST_WORD);
    apb(1'b0, 8'h24, 32'h0, 33'h1_0000_0000);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      c = $urandom;
      m = i == 0 ? 8'h80 : i == 1 ? 8'h01 : i == 2 ? 8'hFF : $urandom;
      wr(`A_COND, c);
      wr(`A_GPR_SEL, 32'h5);
      wr(`A_GPR_DATA, v);
      run({`OP_FIXED, 5'd5, 1'b0, m, 1'b0, `XO_COND_WRITE, 1'b0});
      for (int j = 0; j < 8; j++) mx[4*j +: 4] = {4{m[j]}};
      c = c & ~mx | v & mx;
      rd(`A_COND, c);
    end
    $display("test cond write done");
    s = $urandom;
    wr(`A_SEG_SEL, 32'hA);
    wr(`A_SEG_DATA, s);
    wr(`A_GPR_SEL, 32'h4);
    wr(`A_GPR_DATA, {4'hA, v[27:0]});
    w = {`OP_FIXED, 5'd6, 5'd0, 5'd4, `XO_SEG_READ, 1'b1};
    run(w);
    wr(`A_GPR_SEL, 32'h6);
    rd(`A_GPR_DATA, 32'h0);
    rd(`A_INT_STATUS, 32'h3);
    wr(`A_INT_STATUS, 32'h3);
    wr(`A_CTRL, 32'h1);
    run(w);
    rd(`A_GPR_DATA, s);
    rd(`A_COND, c);
    cmp(irq, 1'b0);
    wr(`A_INT_MASK, 32'h2);
    cmp(irq, 1'b1);
    wr(`A_INT_STATUS, 32'h2);
    cmp(irq, 1'b0);
    $display("test segment and irq done");
    fs = $urandom;
    wr(`A_FSCR, fs);
    for (int k = 0; k < 10; k++) begin
      b = k < 5 ? k : $urandom;
      run({`OP_FLOAT, b, 10'h0, k[0] ? `XO_FS_SET : `XO_FS_CLEAR, k[1]});
      if (b != 1 && b != 2) fs[31-b] = k[0];
      if (k[1]) c[27:24] = fs[31:28];
      rd(`A_FSCR, fs);
      rd(`A_COND, c);
    end
    i_issue_model.q.push_back({`OP_FLOAT, 5'd5, 10'h0, `XO_FS_SET, 1'b0});
    run({`OP_FLOAT, 5'd5, 10'h0, `XO_FS_CLEAR, 1'b0});
    fs[26] = 1'b0;
    rd(`A_FSCR, fs);
    $display("test status bits done");
    end_sim;
  end
endmodule // tb
`default_nettype wire
